// file: hw/epv_cfg.svh
// Constants of the exception priority and vector unit
`ifndef EPV_CFG_SVH
`define EPV_CFG_SVH
`define EPV_VEC_RESET   8'h00
`define EPV_VEC_ILLEGAL 8'h04
`define EPV_VEC_TRACE   8'h05
`define EPV_VEC_TRAP0   8'h08
`define EPV_VEC_CPU_AE  8'h0c
`define EPV_VEC_DMA_AE  8'h0d
`define EPV_VEC_SLEEP   8'h12
`define EPV_RSV_A_LO    8'h01
`define EPV_RSV_A_HI    8'h03
`define EPV_RSV_B       8'h06
`define EPV_RSV_C_LO    8'h0e
`define EPV_RSV_C_HI    8'h11
`define EPV_ICM_TRACE   2'h2
`define EPV_VBR_RESET   32'h00000000
`define EPV_ENTRY_SH    2
`endif

// file: hw/epv_pkg.sv
// Types and shared functions of the exception priority and vector unit
`include "epv_cfg.svh"
package epv_pkg;
  typedef enum logic [2:0]
  {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_FETCH = 3'b100
  } epv_state_e;

  typedef enum logic [2:0]
  {
    KIND_RESET     = 3'h0,
    KIND_ILLEGAL   = 3'h1,
    KIND_TRACE     = 3'h2,
    KIND_ADDR_ERR  = 3'h3,
    KIND_INTERRUPT = 3'h4,
    KIND_SLEEP     = 3'h5,
    KIND_TRAP      = 3'h6
  } epv_kind_e;

  function automatic logic isReservedVec(input logic [7:0] v);
    return (v >= `EPV_RSV_A_LO && v <= `EPV_RSV_A_HI) || (v == `EPV_RSV_B) ||
           (v >= `EPV_RSV_C_LO && v <= `EPV_RSV_C_HI);
  endfunction

  // Only the low 16 address bits carry the table offset
  function automatic logic [15:0] vecOffset(input logic [7:0] v);
    return 16'(v) << `EPV_ENTRY_SH;
  endfunction
endpackage

// file: hw/epv_sel_if.sv
// Request, grant and table address signals between the unit's modules
interface epv_sel_if #(parameter int ADDR_W = 32);
  import epv_pkg::*;
  logic              illegalReq;
  logic              traceReq;
  logic              cpuAeReq;
  logic              dmaAeReq;
  logic              intReq;
  logic              sleepReq;
  logic              trapReq;
  logic [1:0]        trapNum;
  logic [7:0]        intVec;
  logic              grantValid;
  epv_kind_e         grantKind;
  logic [7:0]        grantVec;
  logic [7:0]        curVec;
  logic [ADDR_W-1:0] vector_base_reg;
  logic [ADDR_W-1:0] tableAddr;

  modport ctrl (output illegalReq, traceReq, cpuAeReq, dmaAeReq, intReq, sleepReq, trapReq,
                output trapNum, intVec, curVec, vector_base_reg,
                input  grantValid, grantKind, grantVec, tableAddr);
  modport arb  (input  illegalReq, traceReq, cpuAeReq, dmaAeReq, intReq, sleepReq, trapReq,
                input  trapNum, intVec,
                output grantValid, grantKind, grantVec);
  modport addr (input  curVec, vector_base_reg,
                output tableAddr);
endinterface

// file: hw/epv_arbiter.sv
// Fixed-priority selection of the next exception and its vector number
`include "epv_cfg.svh"
module epv_arbiter
(
  epv_sel_if.arb sel
);
  import epv_pkg::*;

  always_comb
  begin
    sel.grantValid = 1'b1;
    sel.grantKind  = KIND_TRAP;
    sel.grantVec   = `EPV_VEC_TRAP0 + {6'h0, sel.trapNum};
    if (sel.illegalReq)
    begin
      sel.grantKind = KIND_ILLEGAL;
      sel.grantVec  = `EPV_VEC_ILLEGAL;
    end
    else if (sel.traceReq)
    begin
      sel.grantKind = KIND_TRACE;
      sel.grantVec  = `EPV_VEC_TRACE;
    end
    else if (sel.cpuAeReq)
    begin
      sel.grantKind = KIND_ADDR_ERR;
      sel.grantVec  = `EPV_VEC_CPU_AE;
    end
    else if (sel.dmaAeReq)
    begin
      sel.grantKind = KIND_ADDR_ERR;
      sel.grantVec  = `EPV_VEC_DMA_AE;
    end
    else if (sel.intReq)
    begin
      sel.grantKind = KIND_INTERRUPT;
      sel.grantVec  = sel.intVec;
    end
    else if (sel.sleepReq)
    begin
      sel.grantKind = KIND_SLEEP;
      sel.grantVec  = `EPV_VEC_SLEEP;
    end
    else if (!sel.trapReq)
    begin
      sel.grantValid = 1'b0;
    end
  end
endmodule

// file: hw/epv_vec_addr.sv
// Vector table address former
`include "epv_cfg.svh"
module epv_vec_addr #(parameter int ADDR_W = 32)
(
  epv_sel_if.addr sel
);
  import epv_pkg::*;

  logic              noBase;
  logic [ADDR_W-1:0] offset;

  // Reset and CPU address error must work before software sets the base
  assign noBase        = (sel.curVec == `EPV_VEC_RESET) || (sel.curVec == `EPV_VEC_CPU_AE);
  assign offset        = ADDR_W'(vecOffset(sel.curVec));
  assign sel.tableAddr = noBase ? offset : sel.vector_base_reg + offset;
endmodule

// file: hw/epv_unit.sv
// Exception acceptance, priority and vector fetch unit of the CPU
`include "epv_cfg.svh"
module epv_unit #(parameter int ADDR_W = 32)
(
  input  logic                ref_clk,
  input  logic                sys_rst,
  input  logic                clkEn,
  input  logic                externalInitPinN,
  input  logic                wdtOverflow,
  input  logic                instrDone,
  input  logic                lastInstrRte,
  input  logic                lastInstrNoIntSample,
  input  logic                undefOpcode,
  input  logic                addrErrCpu,
  input  logic                addrErrDma,
  input  logic                intReq,
  input  logic [7:0]          intVec,
  input  logic                trapExec,
  input  logic [1:0]          trapNum,
  input  logic                sleepExec,
  input  logic                softwareStandbySelect,
  input  logic                sleepExceptionEnable,
  input  logic                traceFlag,
  input  logic [1:0]          intCtrlMode,
  input  logic                vbrWrEn,
  input  logic [ADDR_W-1:0]   vbrWrData,
  input  logic                vecRdAck,
  input  logic [ADDR_W-1:0]   vecRdData,
  output logic [ADDR_W-1:0]   vectorBaseReg,
  output logic                vecRdReq,
  output logic [ADDR_W-1:0]   vecRdAddr,
  output logic                cpuHalt,
  output logic                excStart,
  output epv_pkg::epv_kind_e  excKind,
  output logic [7:0]          excVector,
  output logic                intAck,
  output logic                handlerValid,
  output logic [ADDR_W-1:0]   handlerAddr
);
  import epv_pkg::*;

  epv_sel_if #(.ADDR_W(ADDR_W)) sel ();

  epv_arbiter u_arb
  (
    .sel (sel)
  );

  epv_vec_addr #(.ADDR_W(ADDR_W)) u_addr
  (
    .sel (sel)
  );

  // ****************************************
  // Boundary and request conditions
  // ****************************************
  epv_state_e        state;
  epv_state_e        next_state;
  logic              pinPrev;
  logic              next_pinPrev;
  logic              lastWasReset;
  logic              next_lastWasReset;
  logic [ADDR_W-1:0] vector_base_reg;
  logic [ADDR_W-1:0] next_vbr;
  logic              next_vecRdReq;
  logic [ADDR_W-1:0] next_vecRdAddr;
  logic              next_excStart;
  epv_kind_e         next_excKind;
  logic [7:0]        next_excVector;
  logic              next_intAck;
  logic              next_handlerValid;
  logic [ADDR_W-1:0] next_handlerAddr;
  logic              illegalPend;
  logic              next_illegalPend;
  logic              cpuAePend;
  logic              next_cpuAePend;
  logic              dmaAePend;
  logic              next_dmaAePend;
  logic              sleepPend;
  logic              next_sleepPend;
  logic              trapPend;
  logic              next_trapPend;
  logic [1:0]        trapSel;
  logic [1:0]        next_trapSel;
  logic              pinLow;
  logic              resetStart;
  logic              excEnd;
  logic              accept;

  assign pinLow     = !externalInitPinN;
  assign resetStart = (!pinPrev && externalInitPinN) || (wdtOverflow && externalInitPinN);
  assign excEnd     = handlerValid;
  assign accept     = (state == ST_RUN) && sel.grantValid && !pinLow && !resetStart;

  assign sel.illegalReq = illegalPend;
  assign sel.traceReq   = traceFlag && (intCtrlMode == `EPV_ICM_TRACE) &&
                          ((instrDone && !lastInstrRte) || excEnd);
  assign sel.cpuAeReq   = cpuAePend && instrDone;
  assign sel.dmaAeReq   = dmaAePend && instrDone;
  // A reserved number from the interrupt side is never passed on
  assign sel.intReq     = intReq && !isReservedVec(intVec) && (instrDone || excEnd) &&
                          !(instrDone && lastInstrNoIntSample) &&
                          !(excEnd && lastWasReset);
  assign sel.sleepReq   = sleepPend;
  assign sel.trapReq    = trapPend;
  assign sel.trapNum    = trapSel;
  assign sel.intVec     = intVec;
  assign sel.curVec     = resetStart ? `EPV_VEC_RESET : sel.grantVec;
  assign sel.vector_base_reg        = vector_base_reg;

  assign cpuHalt       = (state == ST_RESET);
  assign vectorBaseReg = vector_base_reg;

  // ****************************************
  // Pending requests
  // ****************************************
  // A new event in the cycle of its own acceptance stays pending
  always_comb
  begin
    next_illegalPend = illegalPend;
    next_cpuAePend   = cpuAePend;
    next_dmaAePend   = dmaAePend;
    next_sleepPend   = sleepPend;
    next_trapPend    = trapPend;
    next_trapSel     = trapSel;
    if (pinLow || resetStart)
    begin
      next_illegalPend = 1'b0;
      next_cpuAePend   = 1'b0;
      next_dmaAePend   = 1'b0;
      next_sleepPend   = 1'b0;
      next_trapPend    = 1'b0;
    end
    else
    begin
      if (accept && sel.grantKind == KIND_ILLEGAL)
        next_illegalPend = 1'b0;
      if (accept && sel.grantKind == KIND_ADDR_ERR && sel.grantVec == `EPV_VEC_CPU_AE)
        next_cpuAePend = 1'b0;
      if (accept && sel.grantKind == KIND_ADDR_ERR && sel.grantVec == `EPV_VEC_DMA_AE)
        next_dmaAePend = 1'b0;
      if (accept && sel.grantKind == KIND_SLEEP)
        next_sleepPend = 1'b0;
      if (accept && sel.grantKind == KIND_TRAP)
        next_trapPend = 1'b0;
      if (undefOpcode)
        next_illegalPend = 1'b1;
      if (addrErrCpu)
        next_cpuAePend = 1'b1;
      if (addrErrDma)
        next_dmaAePend = 1'b1;
      if (sleepExec && !softwareStandbySelect && sleepExceptionEnable)
        next_sleepPend = 1'b1;
      if (trapExec)
      begin
        next_trapPend = 1'b1;
        next_trapSel  = trapNum;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      illegalPend <= 1'b0;
      cpuAePend   <= 1'b0;
      dmaAePend   <= 1'b0;
      sleepPend   <= 1'b0;
      trapPend    <= 1'b0;
      trapSel     <= 2'h0;
    end
    else if (clkEn)
    begin
      illegalPend <= next_illegalPend;
      cpuAePend   <= next_cpuAePend;
      dmaAePend   <= next_dmaAePend;
      sleepPend   <= next_sleepPend;
      trapPend    <= next_trapPend;
      trapSel     <= next_trapSel;
    end
  end

  // ****************************************
  // Acceptance and vector fetch control
  // ****************************************
  always_comb
  begin
    next_state        = state;
    next_pinPrev      = externalInitPinN;
    next_lastWasReset = lastWasReset;
    next_vbr          = vector_base_reg;
    next_vecRdReq     = vecRdReq;
    next_vecRdAddr    = vecRdAddr;
    next_excStart     = 1'b0;
    next_excKind      = excKind;
    next_excVector    = excVector;
    next_intAck       = 1'b0;
    next_handlerValid = 1'b0;
    next_handlerAddr  = handlerAddr;
    if (pinLow)
    begin
      next_state    = ST_RESET;
      next_vecRdReq = 1'b0;
    end
    else if (resetStart)
    begin
      next_state        = ST_FETCH;
      next_vbr          = ADDR_W'(`EPV_VBR_RESET);
      next_vecRdReq     = 1'b1;
      next_vecRdAddr    = sel.tableAddr;
      next_excStart     = 1'b1;
      next_excKind      = KIND_RESET;
      next_excVector    = `EPV_VEC_RESET;
      next_lastWasReset = 1'b1;
    end
    else
    begin
      case (state)
        ST_RESET:
          next_state = ST_RESET;
        ST_RUN:
        begin
          if (vbrWrEn)
            next_vbr = vbrWrData;
          if (accept)
          begin
            next_state        = ST_FETCH;
            next_vecRdReq     = 1'b1;
            next_vecRdAddr    = sel.tableAddr;
            next_excStart     = 1'b1;
            next_excKind      = sel.grantKind;
            next_excVector    = sel.grantVec;
            next_intAck       = (sel.grantKind == KIND_INTERRUPT);
            next_lastWasReset = 1'b0;
          end
        end
        ST_FETCH:
        begin
          // Requests arriving meanwhile wait until the handler address is in
          if (vecRdAck)
          begin
            next_state        = ST_RUN;
            next_vecRdReq     = 1'b0;
            next_handlerAddr  = vecRdData;
            next_handlerValid = 1'b1;
          end
        end
        default:
          next_state = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state        <= ST_RESET;
      pinPrev      <= 1'b0;
      lastWasReset <= 1'b0;
      vector_base_reg          <= ADDR_W'(`EPV_VBR_RESET);
      vecRdReq     <= 1'b0;
      vecRdAddr    <= '0;
      excStart     <= 1'b0;
      excKind      <= KIND_RESET;
      excVector    <= 8'h00;
      intAck       <= 1'b0;
      handlerValid <= 1'b0;
      handlerAddr  <= '0;
    end
    else if (clkEn)
    begin
      state        <= next_state;
      pinPrev      <= next_pinPrev;
      lastWasReset <= next_lastWasReset;
      vector_base_reg          <= next_vbr;
      vecRdReq     <= next_vecRdReq;
      vecRdAddr    <= next_vecRdAddr;
      excStart     <= next_excStart;
      excKind      <= next_excKind;
      excVector    <= next_excVector;
      intAck       <= next_intAck;
      handlerValid <= next_handlerValid;
      handlerAddr  <= next_handlerAddr;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pin_low_halts: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && pinLow |=> cpuHalt && !excStart)
    else $error("init pin low did not hold reset");
  a_rise_starts_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && resetStart |=> excStart && excKind == KIND_RESET && vecRdReq)
    else $error("reset handling did not start");
  a_vbr_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && resetStart |=> vectorBaseReg == '0)
    else $error("vector base not cleared by reset");
  a_nobase_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
    excStart && (excVector == `EPV_VEC_RESET || excVector == `EPV_VEC_CPU_AE)
      |-> vecRdAddr == ADDR_W'(vecOffset(excVector)))
    else $error("base added to reset or address error vector");
  a_no_reserved: assert property (@(posedge ref_clk) disable iff (sys_rst)
    excStart |-> !isReservedVec(excVector))
    else $error("reserved vector issued");
  a_trace_mode: assert property (@(posedge ref_clk) disable iff (sys_rst)
    excStart && excKind == KIND_TRACE && $past(clkEn) |-> $past(intCtrlMode) == `EPV_ICM_TRACE)
    else $error("trace taken outside mode 2");
  a_no_trace_rte: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && instrDone && lastInstrRte && !excEnd |=> !(excStart && excKind == KIND_TRACE))
    else $error("trace after return from exception");
  a_int_blocked: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && ((instrDone && lastInstrNoIntSample) || (excEnd && lastWasReset)) |=> !intAck)
    else $error("interrupt sampled where forbidden");
  a_illegal_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && state == ST_RUN && illegalPend && !pinLow && !resetStart
      |=> excStart && excKind == KIND_ILLEGAL)
    else $error("illegal instruction lost priority");
  a_fetch_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clkEn && state == ST_FETCH && vecRdAck && !pinLow && !resetStart
      |=> handlerValid && handlerAddr == $past(vecRdData) && !vecRdReq)
    else $error("handler address not taken from table");
endmodule

// file: test/epv_vec_table_model.sv
// Vector table memory model answering the unit's handler fetches
module epv_vec_table_model
(
  input  logic        ref_clk,
  input  logic        sys_rst,
  input  logic        slow,
  input  logic        vecRdReq,
  input  logic [31:0] vecRdAddr,
  output logic        vecRdAck,
  output logic [31:0] vecRdData
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************
  // Table read responder
  // ********************************
  logic [3:0] waitCnt;
  logic       served;

  // Data toggles whenever no entry is driven, so a stale word never passes for an answer
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      waitCnt   <= 4'h0;
      served    <= 1'b0;
      vecRdAck  <= 1'b0;
      vecRdData <= 32'h0;
    end
    else if (!vecRdReq || served)
    begin
      waitCnt   <= 4'h0;
      served    <= vecRdReq;
      vecRdAck  <= 1'b0;
      vecRdData <= ~vecRdData;
    end
    else if (waitCnt == (slow ? 4'h5 : 4'h0))
    begin
      served    <= 1'b1;
      vecRdAck  <= 1'b1;
      vecRdData <= vecRdAddr ^ 32'ha5a50000;
    end
    else
    begin
      waitCnt   <= waitCnt + 4'h1;
      vecRdData <= ~vecRdData;
    end
  end
endmodule

// file: test/test_exception_priority_vector_unit.sv
// Self-checking bench of the exception priority and vector unit
module test_exception_priority_vector_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import epv_pkg::*;

  // ********************************
  // Signals and instances
  // ********************************
  logic        ref_clk, sys_rst, clkEn, externalInitPinN, wdtOverflow, instrDone;
  logic        lastInstrRte, lastInstrNoIntSample, undefOpcode, addrErrCpu, addrErrDma;
  logic        intReq, trapExec, sleepExec, softwareStandbySelect, sleepExceptionEnable;
  logic        traceFlag, vbrWrEn, vecRdAck, vecRdReq, cpuHalt, excStart, intAck;
  logic        handlerValid, slow;
  logic [1:0]  trapNum, intCtrlMode;
  logic [6:0]  ev;
  logic [7:0]  intVec, excVector;
  logic [31:0] vbrWrData, vecRdData, vectorBaseReg, vecRdAddr, handlerAddr, vbrModel;
  epv_kind_e   excKind;
  int          errorCnt, checks, seed;

  // Event bits: watchdog, undefined, trap, sleep, done, cpu error, dma error
  assign {wdtOverflow, undefOpcode, trapExec, sleepExec, instrDone, addrErrCpu, addrErrDma} = ev;

  epv_unit #(.ADDR_W(32)) DUT
  (
    .ref_clk, .sys_rst, .clkEn, .externalInitPinN, .wdtOverflow, .instrDone, .lastInstrRte,
    .lastInstrNoIntSample, .undefOpcode, .addrErrCpu, .addrErrDma, .intReq, .intVec,
    .trapExec, .trapNum, .sleepExec, .softwareStandbySelect, .sleepExceptionEnable,
    .traceFlag, .intCtrlMode, .vbrWrEn, .vbrWrData, .vecRdAck, .vecRdData, .vectorBaseReg,
    .vecRdReq, .vecRdAddr, .cpuHalt, .excStart, .excKind, .excVector, .intAck,
    .handlerValid, .handlerAddr
  );

  epv_vec_table_model model
  (
    .ref_clk, .sys_rst, .slow, .vecRdReq, .vecRdAddr, .vecRdAck, .vecRdData
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // ********************************
  // Helpers
  // ********************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 7'h0;
    #1;
  endtask

  // Bounded wait on excStart (hv=0) or handlerValid (hv=1)
  task automatic waitFor(input bit hv);
    int i;
    i = 0;
    while ((hv ? handlerValid : excStart) !== 1'b1)
    begin
      if (i++ == 60)
      begin
        errorCnt++;
        print_verdict();
      end
      @(posedge ref_clk);
      #1;
    end
  endtask

  // Reset and CPU address error ignore the base
  function automatic logic [31:0] vaddr(input logic [7:0] v);
    return (v == 8'h00 || v == 8'h0c) ? {22'h0, v, 2'h0} : vbrModel + {22'h0, v, 2'h0};
  endfunction

  task automatic expectExc(input logic [2:0] k, input logic [7:0] v);
    waitFor(1'b0);
    cmp(32'(excKind), 32'(k));
    cmp(32'(excVector), 32'(v));
    cmp(vecRdAddr, vaddr(v));
    cmp(32'(intAck), 32'(k == 3'h4));
    cmp(32'(vecRdReq), 32'h1);
    @(posedge ref_clk);
    intReq <= intReq && k != 3'h4;
    traceFlag <= traceFlag && k != 3'h2;
    #1;
    waitFor(1'b1);
    cmp(handlerAddr, vaddr(v) ^ 32'ha5a50000);
    cmp(32'(vecRdReq), 32'h0);
  endtask

  task automatic expectNone(input int n);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      cmp(32'(excStart), 32'h0);
    end
  endtask

  task automatic setVbr(input logic [31:0] v);
    @(posedge ref_clk);
    vbrWrEn <= 1'b1;
    vbrWrData <= v;
    @(posedge ref_clk);
    vbrWrEn <= 1'b0;
    #1;
    vbrModel = v;
    cmp(vectorBaseReg, v);
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial
  begin
    logic [31:0] r;
    logic [7:0]  v;
    int          j;
    int          k;
    seed = 74;
    errorCnt = 0;
    checks = 0;
    vbrModel = 32'h0;
    {clkEn, sys_rst, externalInitPinN} = 3'b111;
    {ev, lastInstrRte, lastInstrNoIntSample, intReq, softwareStandbySelect} = '0;
    {sleepExceptionEnable, traceFlag, vbrWrEn, slow, trapNum, intVec, vbrWrData} = '0;
    intCtrlMode = 2'h2;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    expectExc(3'h0, 8'h00);
    cmp(32'(cpuHalt), 32'h0);
    for (j = 0; j < 6; j++)
    begin
      r = $random(seed);
      v = (j == 0) ? 8'h07 : {2'b01, r[8:3]};
      slow <= r[0];
      trapNum <= r[2:1];
      setVbr({r[31:16], 16'h0});
      pulse(7'h20);
      expectExc(3'h1, 8'h04);
      pulse(7'h10);
      expectExc(3'h6, {6'h2, r[2:1]});
      for (k = 0; k < 4; k++)
      begin
        @(posedge ref_clk);
        {softwareStandbySelect, sleepExceptionEnable} <= 2'(k);
        pulse(7'h08);
        if (k == 1)
          expectExc(3'h5, 8'h12);
        else
          expectNone(6);
      end
      pulse(7'h02);
      expectNone(4);
      pulse(7'h04);
      expectExc(3'h3, 8'h0c);
      pulse(7'h01);
      pulse(7'h04);
      expectExc(3'h3, 8'h0d);
      @(posedge ref_clk);
      intReq <= 1'b1;
      intVec <= v;
      lastInstrNoIntSample <= 1'b1;
      pulse(7'h04);
      expectNone(4);
      @(posedge ref_clk);
      lastInstrNoIntSample <= 1'b0;
      pulse(7'h04);
      expectExc(3'h4, v);
      for (k = 0; k < 4; k++)
      begin
        @(posedge ref_clk);
        traceFlag <= 1'b1;
        intCtrlMode <= 2'(k);
        pulse(7'h04);
        if (k == 2)
          expectExc(3'h2, 8'h05);
        else
          expectNone(4);
      end
      @(posedge ref_clk);
      intCtrlMode <= 2'h2;
      lastInstrRte <= 1'b1;
      pulse(7'h04);
      expectNone(4);
      @(posedge ref_clk);
      traceFlag <= 1'b0;
      lastInstrRte <= 1'b0;
    end
    // Interrupt may only slip in at the illegal handler's end, ahead of sleep and trap
    @(posedge ref_clk);
    intReq <= 1'b1;
    intVec <= 8'h40;
    // The sleep loop leaves standby selected, which would swallow the sleep request
    {softwareStandbySelect, sleepExceptionEnable} <= 2'b01;
    pulse(7'h3a);
    expectExc(3'h1, 8'h04);
    expectExc(3'h4, 8'h40);
    expectExc(3'h5, 8'h12);
    expectExc(3'h6, {6'h2, trapNum});
    expectNone(8);
    pulse(7'h04);
    expectExc(3'h3, 8'h0c);
    setVbr(32'h12340000);
    @(posedge ref_clk);
    externalInitPinN <= 1'b0;
    pulse(7'h20);
    cmp(32'(cpuHalt), 32'h1);
    expectNone(20);
    @(posedge ref_clk);
    externalInitPinN <= 1'b1;
    intReq <= 1'b1;
    intVec <= 8'h07;
    vbrModel = 32'h0;
    expectExc(3'h0, 8'h00);
    cmp(vectorBaseReg, 32'h0);
    expectNone(4);
    pulse(7'h04);
    expectExc(3'h4, 8'h07);
    setVbr(32'h00ab0000);
    pulse(7'h40);
    expectExc(3'h0, 8'h00);
    cmp(vectorBaseReg, 32'h0);
    // Frozen clock enable: an opcode fault seen meanwhile must leave no trace
    @(posedge ref_clk);
    clkEn <= 1'b0;
    pulse(7'h20);
    expectNone(4);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    expectNone(6);
    print_verdict();
  end
endmodule
